// [rtl/mcoc_top.sv]
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module mcoc_top #(
    parameter int TRIM_W = mcoc_pkg::TRIM_W
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SLOW_CLOCK_IN,
    input wire logic RC_OSC_CLK,
    input wire logic XTAL_OSC_CLK,
    input wire logic CRYSTAL_IN_PIN,
    input wire logic [1:0] RC_FREQ_SEL,
    input wire logic [TRIM_W-1:0] FACTORY_TRIM_LOW,
    input wire logic [TRIM_W-1:0] FACTORY_TRIM_MID,
    input wire logic [TRIM_W-1:0] FACTORY_TRIM_HIGH,
    output logic [TRIM_W-1:0] RC_TRIM_OUT,
    output logic XTAL_OSC_EN,
    output logic XTAL_BYPASS_EN,
    output logic CRYSTAL_PINS_TO_OSC,
    output logic [1:0] MAIN_CLOCK_SEL,
    output logic MAIN_CLOCK_OUT,
    output logic CRYSTAL_STABLE_IRQ
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    mcoc_cnt_if cif ();

    logic xtal_en_r;
    logic byp_en_r;
    logic [mcoc_pkg::START_W-1:0] start_cnt_r;
    logic [1:0] src_req_r;
    logic irq_mask_r;
    logic stable_r;
    logic [31:0] cal_r;
    logic [31:0] prdata_r;
    logic [TRIM_W-1:0] trim_r;
    mcoc_pkg::mcoc_src_t src_r;
    mcoc_pkg::mcoc_src_t src_nxt;
    logic slow_s1_r;
    logic slow_s2_r;
    logic slow_s3_r;
    logic wr_access;
    logic ctrl_wr;
    logic en_rise;
    logic en_fall;
    logic [31:0] ctrl_view;
    logic [31:0] stat_view;

    // ****************************************************************
    // Functions
    // ****************************************************************

    // Address decode for the error answer; the read path decodes with its own case.
    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == mcoc_pkg::OSC_CTRL_OFF) || (a == mcoc_pkg::STATUS_OFF) ||
                      (a == mcoc_pkg::IRQ_MASK_OFF) || (a == mcoc_pkg::RC_CAL_OFF);
    endfunction

    // Picks user or factory trim for one frequency setting.
    function automatic logic [TRIM_W-1:0] trim_pick(
        input logic sel,
        input logic [TRIM_W-1:0] user_v,
        input logic [TRIM_W-1:0] fact_v
    );
        trim_pick = sel ? user_v : fact_v;
    endfunction

    // ****************************************************************
    // APB slave
    // ****************************************************************

    // Zero wait states: every transfer completes in its first access cycle.
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_mapped(PADDR);
    assign wr_access = PSEL && PENABLE && PWRITE;
    assign ctrl_wr = wr_access && (PADDR == mcoc_pkg::OSC_CTRL_OFF);
    assign en_rise = ctrl_wr && PWDATA[mcoc_pkg::CTRL_EN_BIT] && !xtal_en_r;
    assign en_fall = ctrl_wr && !PWDATA[mcoc_pkg::CTRL_EN_BIT] && xtal_en_r;

    // Readable images of the control and status words.
    always_comb begin
        ctrl_view = '0;
        ctrl_view[mcoc_pkg::CTRL_EN_BIT] = xtal_en_r;
        ctrl_view[mcoc_pkg::CTRL_BYP_BIT] = byp_en_r;
        ctrl_view[mcoc_pkg::CTRL_START_LSB +: mcoc_pkg::START_W] = start_cnt_r;
        ctrl_view[mcoc_pkg::CTRL_SRC_LSB +: 2] = src_req_r;
        stat_view = '0;
        stat_view[mcoc_pkg::STAT_STABLE_BIT] = stable_r;
        stat_view[mcoc_pkg::STAT_SRC_LSB +: 2] = src_r;
        stat_view[mcoc_pkg::STAT_BUSY_BIT] = cif.busy;
    end

    // Read data is captured in the setup cycle so it stands in a flop.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_r <= '0;
        end else if (CE) begin
            if (PSEL && !PENABLE && !PWRITE) begin
                unique case (PADDR)
                    mcoc_pkg::OSC_CTRL_OFF: prdata_r <= ctrl_view;
                    mcoc_pkg::STATUS_OFF: prdata_r <= stat_view;
                    mcoc_pkg::IRQ_MASK_OFF: prdata_r <= {31'h0000_0000, irq_mask_r};
                    mcoc_pkg::RC_CAL_OFF: prdata_r <= cal_r;
                    default: prdata_r <= '0;
                endcase
            end
        end
    end

    assign PRDATA = prdata_r;

    // ****************************************************************
    // Oscillator control register
    // ****************************************************************

    // Reset leaves the crystal off and asks for the RC source.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            xtal_en_r <= mcoc_pkg::OSC_CTRL_RST[mcoc_pkg::CTRL_EN_BIT];
            byp_en_r <= mcoc_pkg::OSC_CTRL_RST[mcoc_pkg::CTRL_BYP_BIT];
            start_cnt_r <= mcoc_pkg::OSC_CTRL_RST[mcoc_pkg::CTRL_START_LSB +: 8];
            src_req_r <= mcoc_pkg::OSC_CTRL_RST[mcoc_pkg::CTRL_SRC_LSB +: 2];
        end else if (CE && ctrl_wr) begin
            xtal_en_r <= PWDATA[mcoc_pkg::CTRL_EN_BIT];
            byp_en_r <= PWDATA[mcoc_pkg::CTRL_BYP_BIT];
            start_cnt_r <= PWDATA[mcoc_pkg::CTRL_START_LSB +: mcoc_pkg::START_W];
            src_req_r <= PWDATA[mcoc_pkg::CTRL_SRC_LSB +: 2];
        end
    end

    // Mask for the stable interrupt.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_mask_r <= mcoc_pkg::IRQ_MASK_RST;
        end else if (CE && wr_access && (PADDR == mcoc_pkg::IRQ_MASK_OFF)) begin
            irq_mask_r <= PWDATA[mcoc_pkg::MASK_STABLE_BIT];
        end
    end

    // ****************************************************************
    // Slow clock synchroniser and start-up counter
    // ****************************************************************

    // The slow clock is asynchronous; the second and third stages feed the edge detector.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            slow_s1_r <= 1'b0;
            slow_s2_r <= 1'b0;
            slow_s3_r <= 1'b0;
        end else if (CE) begin
            slow_s1_r <= SLOW_CLOCK_IN;
            slow_s2_r <= slow_s1_r;
            slow_s3_r <= slow_s2_r;
        end
    end

    // A write with enable rising restarts the countdown from the new value.
    assign cif.slow_tick = slow_s2_r && !slow_s3_r;
    assign cif.start = en_rise;
    assign cif.load_val = PWDATA[mcoc_pkg::CTRL_START_LSB +: mcoc_pkg::START_W];
    assign cif.abort = en_fall;

    mcoc_startup_cnt u_cnt (
        .CLK(CLK),
        .RST_N(RST_N),
        .CE(CE),
        .cif(cif)
    );

    // ****************************************************************
    // Crystal stable flag
    // ****************************************************************

    // Disable wins over a finishing count: an oscillator being switched off is not stable.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            stable_r <= 1'b0;
        end else if (CE) begin
            if (en_fall || en_rise) begin
                stable_r <= 1'b0;
            end else if (cif.done && xtal_en_r) begin
                stable_r <= 1'b1;
            end else if (!xtal_en_r) begin
                stable_r <= 1'b0;
            end
        end
    end

    // Level request; the flag only clears when the crystal is turned off.
    assign CRYSTAL_STABLE_IRQ = stable_r && irq_mask_r;

    // ****************************************************************
    // Pin handover and main clock source
    // ****************************************************************

    // The pins leave the general-purpose controller as soon as the enable is stored.
    assign XTAL_OSC_EN = xtal_en_r;
    assign XTAL_BYPASS_EN = byp_en_r;
    assign CRYSTAL_PINS_TO_OSC = xtal_en_r || byp_en_r;

    // A source that is not ready falls back to RC, so the system never loses its clock.
    // The disabling write itself drops the crystal, so the mux never holds a dead clock.
    always_comb begin
        unique case (src_req_r)
            mcoc_pkg::REQ_XTAL: src_nxt = (stable_r && !en_fall) ? mcoc_pkg::MCOC_SRC_XTAL
                                                   : mcoc_pkg::MCOC_SRC_RC;
            mcoc_pkg::REQ_BYP: src_nxt = byp_en_r ? mcoc_pkg::MCOC_SRC_BYP
                                                  : mcoc_pkg::MCOC_SRC_RC;
            default: src_nxt = mcoc_pkg::MCOC_SRC_RC;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            src_r <= mcoc_pkg::MCOC_SRC_RC;
        end else if (CE) begin
            src_r <= src_nxt;
        end
    end

    // Plain mux: glitch-free switching is left to the clock cell that follows.
    assign MAIN_CLOCK_SEL = src_r;
    assign MAIN_CLOCK_OUT = (src_r == mcoc_pkg::MCOC_SRC_XTAL) ? XTAL_OSC_CLK :
                            (src_r == mcoc_pkg::MCOC_SRC_BYP) ? CRYSTAL_IN_PIN :
                            RC_OSC_CLK;

    // ****************************************************************
    // RC oscillator calibration
    // ****************************************************************

    // Cleared by every reset; factory values come from pins and are never written.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cal_r <= mcoc_pkg::RC_CAL_RST;
        end else if (CE && wr_access && (PADDR == mcoc_pkg::RC_CAL_OFF)) begin
            cal_r <= PWDATA & 32'h00FF_FFFF;
        end
    end

    // Trim follows the register one clock later, even while the RC clock is in use.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            trim_r <= '0;
        end else if (CE) begin
            unique case (RC_FREQ_SEL)
                2'h0: trim_r <= trim_pick(cal_r[mcoc_pkg::CAL_LOW_LSB + mcoc_pkg::CAL_SEL_OFS],
                    cal_r[mcoc_pkg::CAL_LOW_LSB +: TRIM_W], FACTORY_TRIM_LOW);
                2'h1: trim_r <= trim_pick(cal_r[mcoc_pkg::CAL_MID_LSB + mcoc_pkg::CAL_SEL_OFS],
                    cal_r[mcoc_pkg::CAL_MID_LSB +: TRIM_W], FACTORY_TRIM_MID);
                default: trim_r <= trim_pick(
                    cal_r[mcoc_pkg::CAL_HIGH_LSB + mcoc_pkg::CAL_SEL_OFS],
                    cal_r[mcoc_pkg::CAL_HIGH_LSB +: TRIM_W], FACTORY_TRIM_HIGH);
            endcase
        end
    end

    assign RC_TRIM_OUT = trim_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    off_not_stable_a: assert property (
        @(posedge CLK) disable iff (!RST_N) !xtal_en_r |-> !stable_r
    ) else $error("stable flag set while crystal disabled");

    disable_clears_a: assert property (
        @(posedge CLK) disable iff (!RST_N) (CE && en_fall) |=> (!xtal_en_r && !stable_r)
    ) else $error("disable did not clear stable flag");

    enable_starts_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (CE && en_rise && !cif.abort) |=> (cif.busy && !stable_r)
    ) else $error("enable did not start countdown");

    done_sets_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (CE && cif.done && xtal_en_r && !ctrl_wr) |=> stable_r
    ) else $error("countdown end did not set stable flag");

    stable_hold_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (stable_r && !ctrl_wr) |=> stable_r
    ) else $error("stable flag dropped while crystal enabled");

    irq_raise_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        ($rose(stable_r) && irq_mask_r) |-> CRYSTAL_STABLE_IRQ
    ) else $error("interrupt missing on stable");

    xtal_src_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (src_r == mcoc_pkg::MCOC_SRC_XTAL) |-> ($past(stable_r) && xtal_en_r)
    ) else $error("crystal selected before stable");

    factory_trim_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (CE && RC_FREQ_SEL == 2'h0 && !cal_r[mcoc_pkg::CAL_LOW_LSB + mcoc_pkg::CAL_SEL_OFS])
        |=> (RC_TRIM_OUT == $past(FACTORY_TRIM_LOW))
    ) else $error("factory trim not applied");

    user_trim_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (CE && RC_FREQ_SEL == 2'h1 && cal_r[mcoc_pkg::CAL_MID_LSB + mcoc_pkg::CAL_SEL_OFS])
        |=> (RC_TRIM_OUT == $past(cal_r[mcoc_pkg::CAL_MID_LSB +: TRIM_W]))
    ) else $error("user trim not applied");

    pins_follow_a: assert property (
        @(posedge CLK) disable iff (!RST_N) xtal_en_r |-> CRYSTAL_PINS_TO_OSC
    ) else $error("crystal pins not handed to oscillator");

    ce_freeze_a: assert property (
        @(posedge CLK) disable iff (!RST_N) !CE |=> ($stable(stable_r) && $stable(trim_r))
    ) else $error("state changed while clock enable low");

endmodule

`default_nettype wire

// [rtl/mcoc_pkg.sv]
package mcoc_pkg;

    // ****************************************************************
    // Register offsets (byte addresses on the APB)
    // ****************************************************************
    localparam logic [11:0] OSC_CTRL_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h008;
    localparam logic [11:0] RC_CAL_OFF = 12'h00C;

    // ****************************************************************
    // Field layouts
    // ****************************************************************
    localparam int TRIM_W = 7;
    localparam int START_W = 8;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_BYP_BIT = 1;
    localparam int CTRL_START_LSB = 8;
    localparam int CTRL_SRC_LSB = 24;
    localparam int STAT_STABLE_BIT = 0;
    localparam int STAT_SRC_LSB = 1;
    localparam int STAT_BUSY_BIT = 3;
    localparam int MASK_STABLE_BIT = 0;
    localparam int CAL_LOW_LSB = 0;
    localparam int CAL_MID_LSB = 8;
    localparam int CAL_HIGH_LSB = 16;
    localparam int CAL_SEL_OFS = 7;

    // ****************************************************************
    // Reset values and timing counts
    // ****************************************************************
    localparam logic [31:0] OSC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] RC_CAL_RST = 32'h0000_0000;
    localparam logic IRQ_MASK_RST = 1'b0;
    localparam int SLOW_DIV = 8;
    localparam int UNIT_DIV_TICKS = 32;
    localparam int PRESCALE_W = 8;

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        MCOC_SRC_RC = 2'h0,
        MCOC_SRC_XTAL = 2'h1,
        MCOC_SRC_BYP = 2'h3
    } mcoc_src_t;

    typedef enum logic [1:0] {
        MCOC_CNT_IDLE = 2'h0,
        MCOC_CNT_RUN = 2'h1,
        MCOC_CNT_DONE = 2'h3
    } mcoc_cnt_t;

    localparam logic [1:0] REQ_RC = 2'h0;
    localparam logic [1:0] REQ_XTAL = 2'h1;
    localparam logic [1:0] REQ_BYP = 2'h2;

endpackage

// [rtl/mcoc_cnt_if.sv]
`timescale 1ns/10ps
`default_nettype none

// Link between the control logic and the start-up counter.
interface mcoc_cnt_if;
    logic start;
    logic abort;
    logic slow_tick;
    logic [mcoc_pkg::START_W-1:0] load_val;
    logic busy;
    logic done;

    modport ctrl (output start, output abort, output slow_tick, output load_val,
                  input busy, input done);
    modport cnt (input start, input abort, input slow_tick, input load_val,
                 output busy, output done);
endinterface

`default_nettype wire

// [rtl/mcoc_startup_cnt.sv]
`timescale 1ns/10ps
`default_nettype none

module mcoc_startup_cnt (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    mcoc_cnt_if.cnt cif
);

    // ****************************************************************
    // Start-up down-counter on the divided slow clock
    // ****************************************************************
    mcoc_pkg::mcoc_cnt_t state_r;
    logic [mcoc_pkg::START_W-1:0] count_r;
    logic [mcoc_pkg::PRESCALE_W-1:0] pre_r;
    logic unit_end;

    // One count unit is eight slow edges times the unit divider.
    assign unit_end = cif.slow_tick &&
        (pre_r == mcoc_pkg::PRESCALE_W'(mcoc_pkg::SLOW_DIV * mcoc_pkg::UNIT_DIV_TICKS - 1));

    // Abort beats a pending finish, since a disabled oscillator is never stable.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= mcoc_pkg::MCOC_CNT_IDLE;
            count_r <= '0;
            pre_r <= '0;
        end else if (CE) begin
            if (cif.abort) begin
                state_r <= mcoc_pkg::MCOC_CNT_IDLE;
            end else if (cif.start) begin
                count_r <= cif.load_val;
                pre_r <= '0;
                state_r <= (cif.load_val == '0) ? mcoc_pkg::MCOC_CNT_DONE
                                                : mcoc_pkg::MCOC_CNT_RUN;
            end else begin
                unique case (state_r)
                    mcoc_pkg::MCOC_CNT_IDLE: begin
                        state_r <= mcoc_pkg::MCOC_CNT_IDLE;
                    end
                    mcoc_pkg::MCOC_CNT_RUN: begin
                        if (cif.slow_tick) begin
                            pre_r <= pre_r + 1'b1;
                        end
                        if (unit_end) begin
                            count_r <= count_r - 1'b1;
                            if (count_r == 8'h01) begin
                                state_r <= mcoc_pkg::MCOC_CNT_DONE;
                            end
                        end
                    end
                    mcoc_pkg::MCOC_CNT_DONE: begin
                        state_r <= mcoc_pkg::MCOC_CNT_IDLE;
                    end
                    default: begin
                        state_r <= mcoc_pkg::MCOC_CNT_IDLE;
                    end
                endcase
            end
        end
    end

    // Done is a one-cycle pulse; busy covers the whole countdown.
    assign cif.done = (state_r == mcoc_pkg::MCOC_CNT_DONE);
    assign cif.busy = (state_r != mcoc_pkg::MCOC_CNT_IDLE);

endmodule

`default_nettype wire

// [bench/mcoc_xtal_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// External crystal, bypass clock source and slow clock source
// ****************************************************************
module mcoc_xtal_model (
    input wire logic osc_en,
    output logic xtal_clk,
    output logic pin_clk,
    output logic slow_clk
);
    // The resonator only swings while the oscillator amplifier runs.
    // An off oscillator stands still low, so a mux that keeps it
    // selected shows a dead clock.
    initial begin
        xtal_clk = 1'b0;
        forever begin
            #6;
            xtal_clk = osc_en ? ~xtal_clk : 1'b0;
        end
    end

    // An external clock generator on the input pin runs free.
    initial begin
        pin_clk = 1'b0;
        forever #7 pin_clk = ~pin_clk;
    end

    // Slow clock, much faster than the real one to keep runs short.
    // Its period is not a multiple of the system clock on purpose.
    initial begin
        slow_clk = 1'b0;
        forever #20.5 slow_clk = ~slow_clk;
    end
endmodule

`default_nettype wire

// [bench/mcoc_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module mcoc_top_tb;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic xclk, bclk, sclk, osc_en, byp_en, pins, mclk, irq, ce;
    logic [1:0] fsel, msel;
    logic [6:0] trim_out;
    logic [6:0] f [3];
    logic [32:0] q [$];
    logic [15:0] rnd;
    int fail_count, checks, n;

    mcoc_top dut_u (.CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SLOW_CLOCK_IN(sclk), .RC_OSC_CLK(~clk), .XTAL_OSC_CLK(xclk),
        .CRYSTAL_IN_PIN(bclk), .RC_FREQ_SEL(fsel), .FACTORY_TRIM_LOW(f[0]),
        .FACTORY_TRIM_MID(f[1]), .FACTORY_TRIM_HIGH(f[2]),
        .RC_TRIM_OUT(trim_out), .XTAL_OSC_EN(osc_en), .XTAL_BYPASS_EN(byp_en),
        .CRYSTAL_PINS_TO_OSC(pins), .MAIN_CLOCK_SEL(msel),
        .MAIN_CLOCK_OUT(mclk), .CRYSTAL_STABLE_IRQ(irq));

    mcoc_xtal_model xtal_u (.osc_en(osc_en), .xtal_clk(xclk), .pin_clk(bclk),
        .slow_clk(sclk));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Reads note the expected {error, data} pair; the monitor checks it.
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, input logic [32:0] exp);
        if (!w) q.push_back(exp);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a slave that never answers.
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Applied trim per frequency setting, user value only when selected.
    task automatic trim_sweep(input logic [31:0] cal);
        apb(1'b1, mcoc_pkg::RC_CAL_OFF, cal, 33'h0);
        apb(1'b0, mcoc_pkg::RC_CAL_OFF, 32'h0, {9'h0, cal[23:0]});
        for (int s = 0; s < 3; s++) begin
            fsel <= 2'(s);
            repeat (3) @(posedge clk);
            #1 check(33'(trim_out), 33'(cal[s*8+7] ? cal[s*8+:7] : f[s]));
        end
    endtask

    // The access-phase edge carries the data captured at setup.
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && q.size() > 0)
            check({pslverr, prdata}, q.pop_front());
    end

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, fsel} = '0;
        ce = 1'b1;
        rst_n = 1'b0;
        rnd = 16'h0011;
        for (int s = 0; s < 3; s++) begin
            rnd = lfsr(rnd);
            f[s] = rnd[6:0];
        end
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        #1 check(33'({osc_en, pins, msel}), 33'h0);
        apb(1'b0, mcoc_pkg::OSC_CTRL_OFF, 32'h0, 33'h0);
        apb(1'b0, mcoc_pkg::STATUS_OFF, 32'h0, 33'h0);
        apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
        trim_sweep(32'h0);
        rnd = lfsr(rnd);
        trim_sweep({8'h0, 1'b1, rnd[14:8], 1'b1, rnd[6:0], 1'b1, rnd[14:8]});
        trim_sweep({8'h0, 1'b1, rnd[6:0], 1'b0, rnd[14:8], 1'b1, rnd[6:0]});
        // Clock enable low freezes the applied trim although the setting moves.
        @(posedge clk);
        ce <= 1'b0;
        fsel <= 2'h0;
        repeat (3) @(posedge clk);
        #1 check(33'(trim_out), 33'(rnd[6:0]));
        @(posedge clk);
        ce <= 1'b1;
        // Crystal start with a count of one unit and crystal requested.
        apb(1'b1, mcoc_pkg::IRQ_MASK_OFF, 32'h1, 33'h0);
        apb(1'b1, mcoc_pkg::OSC_CTRL_OFF, 32'h0100_0101, 33'h0);
        #1 check(33'({osc_en, pins}), 33'h3);
        apb(1'b0, mcoc_pkg::STATUS_OFF, 32'h0, 33'h8);
        for (n = 0; n < 2000; n++) begin
            @(posedge clk);
            if (irq === 1'b1) break;
        end
        // 256 slow periods of 41 ns plus synchroniser latency.
        check(33'(n >= 1290 && n <= 1330), 33'h1);
        repeat (2) @(posedge clk);
        #1 check(33'({irq, msel}), 33'h5);
        check(33'(mclk === xclk), 33'h1);
        repeat (40) @(posedge clk);
        apb(1'b0, mcoc_pkg::STATUS_OFF, 32'h0, 33'h3);
        // Back to the RC source before any low-power entry.
        apb(1'b1, mcoc_pkg::OSC_CTRL_OFF, 32'h0000_0100, 33'h0);
        #1 check(33'(irq), 33'h0);
        apb(1'b0, mcoc_pkg::STATUS_OFF, 32'h0, 33'h0);
        // Zero start-up count is the shortest wait there is.
        apb(1'b1, mcoc_pkg::OSC_CTRL_OFF, 32'h0000_0001, 33'h0);
        repeat (4) @(posedge clk);
        apb(1'b0, mcoc_pkg::STATUS_OFF, 32'h0, 33'h1);
        // Bypass source on the input pin.
        apb(1'b1, mcoc_pkg::OSC_CTRL_OFF, 32'h0200_0002, 33'h0);
        repeat (3) @(posedge clk);
        #1 check(33'({byp_en, pins, msel}), 33'hF);
        check(33'(mclk === bclk), 33'h1);
        apb(1'b1, mcoc_pkg::OSC_CTRL_OFF, 32'h0, 33'h0);
        // A second reset in mid-run drops the user trims.
        apb(1'b1, mcoc_pkg::RC_CAL_OFF, 32'h0080_8080, 33'h0);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, mcoc_pkg::RC_CAL_OFF, 32'h0, 33'h0);
        #1 check(33'({osc_en, msel}), 33'h0);
        check(33'(trim_out), 33'(f[0]));
        repeat (2) @(posedge clk);
        report_and_stop();
    end
endmodule

`default_nettype wire
